// ===== verilog/rtcw_params.svh
// Constants of the real-time clock core: offsets, fields, reset values, timing
`ifndef RTCW_PARAMS_SVH
`define RTCW_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RTCW_A_TIME_LAST 5'h07
`define RTCW_A_ALM_SEC   5'h08
`define RTCW_A_ALM_DAY   5'h0B
`define RTCW_A_WD_FRAC   5'h0C
`define RTCW_A_WD_SEC    5'h0D
`define RTCW_A_FLAGS     5'h0E
`define RTCW_A_CTRL      5'h0F

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RTCW_CTL_TE   7
`define RTCW_CTL_OSC  6
`define RTCW_CTL_WDE  5
`define RTCW_CTL_WDS  4
`define RTCW_CTL_TIE  3
`define RTCW_CTL_TPE  2
`define RTCW_FLG_ALM  0
`define RTCW_FLG_WD   1
`define RTCW_FLG_IRQ  2
`define RTCW_ALM_MASK 7
`define RTCW_ALM_DYDT 6
`define RTCW_CTRL_RST 8'h80
`define RTCW_CAL_RST  8'h01
`define RTCW_ZERO_RST 8'h00

// ----------------------------------------------------------------------------
// BCD limits and timing
// ----------------------------------------------------------------------------
`define RTCW_MAX_SEC  8'h59
`define RTCW_MAX_HOUR 8'h23
`define RTCW_MAX_WDAY 8'h07
`define RTCW_MAX_MON  8'h12
`define RTCW_MAX_YEAR 8'h99
`define RTCW_CLK_NS      5
`define RTCW_TICK_NS     10_000_000
`define RTCW_TICK_CYC    (`RTCW_TICK_NS / `RTCW_CLK_NS)
`define RTCW_TICKS_SEC   7'd99
`define RTCW_RST_MIN_NS  40_000_000
`define RTCW_RST_MAX_NS  200_000_000
`define RTCW_RST_CYC     ((`RTCW_RST_MIN_NS + `RTCW_CLK_NS - 1) / `RTCW_CLK_NS)

`endif

// ===== verilog/rtcw_pkg.sv
// Types shared by the real-time clock core
`default_nettype none
package rtcw_pkg;
  typedef logic [7:0] rtcw_byte_t;
  typedef struct packed {
    logic       cs_n;
    logic       oe_n;
    logic       we_n;
    logic [4:0] addr;
    logic [7:0] data;
  } rtcw_bus_s;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } rtcw_bus_e;
endpackage
`default_nettype wire

// ===== verilog/rtcw_core.sv
// Real-time clock core with alarm, watchdog and power-fail reset
`include "rtcw_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rtcw_core
  import rtcw_pkg::*;
#(
  parameter int RST_CYC  = `RTCW_RST_CYC,
  parameter int TICK_CYC = `RTCW_TICK_CYC
)(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire rtcw_bus_s  bus_in,
  input  wire logic       power_fail_in,
  output logic [7:0]      dq_out,
  output logic            dq_oe_out,
  output logic            irq_oe_out,
  output logic            power_on_oe_out,
  output logic            reset_oe_out
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rsync_q;
  logic       rst_n;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in) rsync_q <= 2'b00;
    else           rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [8:0] bcd_inc(input rtcw_byte_t v, input rtcw_byte_t mx,
                                         input rtcw_byte_t mn);
    if (v >= mx)             bcd_inc = {1'b1, mn};
    else if (v[3:0] >= 4'h9) bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
    else                     bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic rtcw_byte_t days_in(input rtcw_byte_t mon, input rtcw_byte_t yr);
    logic leap;
    leap = (2'(yr[3:0]) + {yr[4], 1'b0}) == 2'b00;
    case (mon)
      8'h02:                      days_in = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default:                    days_in = 8'h31;
    endcase
  endfunction

  function automatic logic [13:0] bcd2bin(input rtcw_byte_t hi, input rtcw_byte_t lo);
    bcd2bin = 14'(hi[7:4]) * 14'd1000 + 14'(hi[3:0]) * 14'd100
            + 14'(lo[7:4]) * 14'd10 + 14'(lo[3:0]);
  endfunction

  // --------------------------------------------------------------------------
  // Host port
  // --------------------------------------------------------------------------
  rtcw_bus_e  bus_q, bus_d;
  logic [4:0] wadr_q;
  rtcw_byte_t wdat_q, rdat;
  logic       wr_go, fl_rd, fl_rd_q, fl_clr;
  logic       pf;
  assign pf = power_fail_in;

  always_comb
  begin
    if (pf || bus_in.cs_n)  bus_d = BUS_IDLE;
    else if (!bus_in.we_n)  bus_d = BUS_WRITE;
    else                    bus_d = BUS_READ;
  end

  // Later of the two strobes opens the write; commit when it closes
  assign wr_go = (bus_q == BUS_WRITE) && (bus_d != BUS_WRITE) && !pf;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_q  <= BUS_IDLE;
      wadr_q <= 5'h00;
      wdat_q <= `RTCW_ZERO_RST;
    end
    else
    begin
      case (bus_d)
        BUS_WRITE:
        begin
          wadr_q <= bus_in.addr;
          wdat_q <= bus_in.data;
        end
        BUS_READ, BUS_IDLE: ;
        default: ;
      endcase
      bus_q <= bus_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  rtcw_byte_t tm_q [8];
  rtcw_byte_t ext_q [8];
  rtcw_byte_t tm_nx [8];
  rtcw_byte_t al_q [4];
  rtcw_byte_t wd_lo_q, wd_hi_q, ctl_q;
  logic [7:0] dirty_q;
  logic       alm_f_q, wd_f_q, irq_f_q;
  logic       sec_tick, sec_q, tick10, al_hit, wd_to, wd_rst;
  logic       te_rise;

  assign te_rise = wr_go && wadr_q == `RTCW_A_CTRL && wdat_q[`RTCW_CTL_TE]
                   && !ctl_q[`RTCW_CTL_TE];

  always_comb
  begin
    logic [8:0] s, m, h, w, d, mo, y, c;
    s  = bcd_inc(tm_q[0], `RTCW_MAX_SEC, `RTCW_ZERO_RST);
    m  = s[8] ? bcd_inc(tm_q[1], `RTCW_MAX_SEC, `RTCW_ZERO_RST) : {1'b0, tm_q[1]};
    h  = m[8] ? bcd_inc(tm_q[2], `RTCW_MAX_HOUR, `RTCW_ZERO_RST) : {1'b0, tm_q[2]};
    w  = h[8] ? bcd_inc(tm_q[3], `RTCW_MAX_WDAY, `RTCW_CAL_RST) : {1'b0, tm_q[3]};
    d  = h[8] ? bcd_inc(tm_q[4], days_in(tm_q[5], tm_q[6]), `RTCW_CAL_RST) : {1'b0, tm_q[4]};
    mo = d[8] ? bcd_inc(tm_q[5], `RTCW_MAX_MON, `RTCW_CAL_RST) : {1'b0, tm_q[5]};
    y  = mo[8] ? bcd_inc(tm_q[6], `RTCW_MAX_YEAR, `RTCW_ZERO_RST) : {1'b0, tm_q[6]};
    c  = y[8] ? bcd_inc(tm_q[7], `RTCW_MAX_YEAR, `RTCW_ZERO_RST) : {1'b0, tm_q[7]};
    tm_nx = '{s[7:0], m[7:0], h[7:0], w[7:0], d[7:0], mo[7:0], y[7:0], c[7:0]};
  end

  // Internal counters: counting unless the oscillator is stopped, loaded from held writes on enable
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        tm_q[i] <= (i >= 3 && i <= 5) ? `RTCW_CAL_RST : `RTCW_ZERO_RST;
    end
    else if (te_rise)
    begin
      for (int i = 0; i < 8; i++)
        if (dirty_q[i]) tm_q[i] <= ext_q[i];
    end
    else if (wr_go && wadr_q <= `RTCW_A_TIME_LAST && ctl_q[`RTCW_CTL_TE])
      tm_q[wadr_q[2:0]] <= wdat_q;
    else if (sec_tick)
      tm_q <= tm_nx;
  end

  // Visible copy follows the counters only while transfer is enabled
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++) ext_q[i] <= `RTCW_ZERO_RST;
      dirty_q <= 8'h00;
    end
    else if (wr_go && wadr_q <= `RTCW_A_TIME_LAST && !ctl_q[`RTCW_CTL_TE])
    begin
      ext_q[wadr_q[2:0]]   <= wdat_q;
      dirty_q[wadr_q[2:0]] <= 1'b1;
    end
    else if (ctl_q[`RTCW_CTL_TE] && !te_rise)
    begin
      ext_q   <= tm_q;
      dirty_q <= 8'h00;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++) al_q[i] <= `RTCW_ZERO_RST;
      wd_lo_q <= `RTCW_ZERO_RST;
      wd_hi_q <= `RTCW_ZERO_RST;
    end
    else if (wr_go)
    begin
      if (wadr_q >= `RTCW_A_ALM_SEC && wadr_q <= `RTCW_A_ALM_DAY) al_q[wadr_q[1:0]] <= wdat_q;
      if (wadr_q == `RTCW_A_WD_FRAC) wd_lo_q <= wdat_q;
      if (wadr_q == `RTCW_A_WD_SEC)  wd_hi_q <= wdat_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      ctl_q <= `RTCW_CTRL_RST;
    else if (wr_go && wadr_q == `RTCW_A_CTRL)
      ctl_q <= wdat_q;
    else if (wd_rst)
      ctl_q[`RTCW_CTL_WDE] <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Timebase: 10 ms ticks, 100 per second, all halted by oscillator stop
  // --------------------------------------------------------------------------
  logic [20:0] pre_q;
  logic [6:0]  centi_q;
  assign tick10   = !ctl_q[`RTCW_CTL_OSC] && pre_q == 21'(TICK_CYC - 1);
  assign sec_tick = tick10 && centi_q == `RTCW_TICKS_SEC;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q   <= 21'h0_0000;
      centi_q <= 7'h00;
      sec_q   <= 1'b0;
    end
    else
    begin
      if (!ctl_q[`RTCW_CTL_OSC]) pre_q <= tick10 ? 21'h0_0000 : pre_q + 21'h0_0001;
      if (tick10) centi_q <= sec_tick ? 7'h00 : centi_q + 7'h01;
      sec_q <= sec_tick;
    end
  end

  // --------------------------------------------------------------------------
  // Alarm
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic sm, mm, hm, dm;
    sm = tm_q[0][6:0] == al_q[0][6:0];
    mm = tm_q[1][6:0] == al_q[1][6:0];
    hm = tm_q[2][5:0] == al_q[2][5:0];
    dm = al_q[3][`RTCW_ALM_DYDT] ? tm_q[3][2:0] == al_q[3][2:0]
                                 : tm_q[4][5:0] == al_q[3][5:0];
    casez ({al_q[3][`RTCW_ALM_MASK], al_q[2][`RTCW_ALM_MASK],
            al_q[1][`RTCW_ALM_MASK], al_q[0][`RTCW_ALM_MASK]})
      4'b?111: al_hit = 1'b1;
      4'b?110: al_hit = sm;
      4'b?100: al_hit = sm && mm;
      4'b1000: al_hit = sm && mm && hm;
      4'b0000: al_hit = sm && mm && hm && dm;
      default: al_hit = 1'b1;
    endcase
  end

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  logic [13:0] wd_cnt_q, wd_load;
  logic        wd_rl_q, wd_on;
  assign wd_load = bcd2bin(wd_hi_q, wd_lo_q);
  assign wd_on   = wd_load != 14'd0;
  assign wd_to   = wd_on && !wd_rl_q && tick10 && wd_cnt_q <= 14'd1;
  assign wd_rst  = wd_to && ctl_q[`RTCW_CTL_WDE] && ctl_q[`RTCW_CTL_WDS];

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_cnt_q <= 14'd0;
      wd_rl_q  <= 1'b0;
    end
    else
    begin
      wd_rl_q <= wr_go && (wadr_q == `RTCW_A_WD_FRAC || wadr_q == `RTCW_A_WD_SEC);
      if (wd_rl_q || wd_to) wd_cnt_q <= wd_load;
      else if (tick10 && wd_on) wd_cnt_q <= wd_cnt_q - 14'd1;
    end
  end

  // --------------------------------------------------------------------------
  // Flags: a set in the clearing cycle wins
  // --------------------------------------------------------------------------
  logic al_set, irq_set;
  assign fl_rd   = !pf && !bus_in.cs_n && !bus_in.oe_n && bus_in.we_n
                   && bus_in.addr == `RTCW_A_FLAGS;
  // Power fail ends the read condition too, but must not count as a flag read
  assign fl_clr  = fl_rd_q && !fl_rd && !pf;
  assign al_set  = sec_q && al_hit;
  assign irq_set = (al_set && ctl_q[`RTCW_CTL_TIE])
                   || (wd_to && ctl_q[`RTCW_CTL_WDE] && !ctl_q[`RTCW_CTL_WDS]);

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fl_rd_q <= 1'b0;
      alm_f_q <= 1'b0;
      wd_f_q  <= 1'b0;
      irq_f_q <= 1'b0;
    end
    else
    begin
      fl_rd_q <= fl_rd;
      alm_f_q <= al_set || (alm_f_q && !fl_clr);
      wd_f_q  <= wd_to || (wd_f_q && !fl_clr);
      irq_f_q <= irq_set || (irq_f_q && !fl_clr);
    end
  end

  // --------------------------------------------------------------------------
  // Read data and pins
  // --------------------------------------------------------------------------
  always_comb
  begin
    rdat = `RTCW_ZERO_RST;
    if (bus_in.addr <= `RTCW_A_TIME_LAST) rdat = ext_q[bus_in.addr[2:0]];
    else if (bus_in.addr <= `RTCW_A_ALM_DAY) rdat = al_q[bus_in.addr[1:0]];
    else if (bus_in.addr == `RTCW_A_WD_FRAC) rdat = wd_lo_q;
    else if (bus_in.addr == `RTCW_A_WD_SEC) rdat = wd_hi_q;
    else if (bus_in.addr == `RTCW_A_FLAGS) rdat = {5'h00, irq_f_q, wd_f_q, alm_f_q};
    else if (bus_in.addr == `RTCW_A_CTRL) rdat = ctl_q;
  end

  // Reset hold counter; power fail reloads it so release is timed from return
  logic [22:0] rcnt_q;
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n) rcnt_q <= 23'h00_0000;
    else if (pf || wd_rst) rcnt_q <= 23'(RST_CYC);
    else if (rcnt_q != 23'h00_0000) rcnt_q <= rcnt_q - 23'h00_0001;
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out          <= `RTCW_ZERO_RST;
      dq_oe_out       <= 1'b0;
      irq_oe_out      <= 1'b0;
      power_on_oe_out <= 1'b0;
      reset_oe_out    <= 1'b1;
    end
    else
    begin
      dq_out          <= rdat;
      dq_oe_out       <= !pf && !bus_in.cs_n && !bus_in.oe_n && bus_in.we_n;
      irq_oe_out      <= !pf && irq_f_q;
      power_on_oe_out <= alm_f_q && ctl_q[`RTCW_CTL_TPE];
      reset_oe_out    <= pf || rcnt_q != 23'h00_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  ctrl_write_a: assert property (wr_go && wadr_q == `RTCW_A_CTRL && !wd_rst
    |=> ctl_q == $past(wdat_q)) else $error("control write not stored");
  read_release_a: assert property (!bus_in.we_n |=> !dq_oe_out)
    else $error("data driven during write strobe");
  pf_float_a: assert property (pf |=> !dq_oe_out && reset_oe_out && !wr_go)
    else $error("access during power fail");
  rst_hold_a: assert property ($fell(pf) && RST_CYC > 9 |-> reset_oe_out [*8])
    else $error("reset released too early");
  osc_halt_a: assert property (ctl_q[`RTCW_CTL_OSC] |=> $stable(pre_q) && $stable(tm_q[0]))
    else $error("counting while oscillator stopped");
  hold_freeze_a: assert property (!ctl_q[`RTCW_CTL_TE] && !wr_go |=> $stable(ext_q[0]))
    else $error("held time changed");
  alarm_flag_a: assert property (al_set |=> alm_f_q)
    else $error("alarm flag not set");
  wd_reload_a: assert property (wd_rl_q |=> wd_cnt_q == $past(wd_load))
    else $error("watchdog not reloaded");
  wd_steer_a: assert property (wd_rst |=> !ctl_q[`RTCW_CTL_WDE] && wd_f_q ##1 reset_oe_out)
    else $error("watchdog reset steering wrong");
  flag_clear_a: assert property (fl_clr && !al_set && !wd_to && !irq_set
    |=> !alm_f_q && !wd_f_q && !irq_f_q) else $error("flags not cleared");

  write_c:   cover property (wr_go);
  alarm_c:   cover property (al_set && ctl_q[`RTCW_CTL_TIE]);
  wd_to_c:   cover property (wd_to);
  flg_clr_c: cover property (fl_clr && alm_f_q);

endmodule // rtcw_core
`default_nettype wire

// ===== verif/rtcw_host.sv
// Host processor model driving the bytewide register bus of the clock core
`timescale 1ns/100ps
`default_nettype none
module rtcw_host
  import rtcw_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic [7:0] dq_in,
  input  wire logic       dq_oe_in,
  output var  rtcw_bus_s  bus_out
);
  logic       cs_n = 1'b1;
  logic       oe_n = 1'b1;
  logic       we_n = 1'b1;
  logic [4:0] addr = 5'h00;
  rtcw_byte_t hdata = 8'h00;
  logic       hdrive = 1'b0;
  rtcw_byte_t last = 8'h5A;

  // Undriven data lines show the inverse of the last value, never a stale copy
  assign bus_out = '{cs_n: cs_n, oe_n: oe_n, we_n: we_n, addr: addr,
                     data: hdrive ? hdata : (dq_oe_in ? dq_in : ~last)};

  // --------------------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input rtcw_byte_t d, input logic oe_low,
                    output logic drv, output logic flt);
    @(negedge mclk_in);
    addr = a;
    cs_n = 1'b0;
    oe_n = !oe_low;
    if (oe_low)
      repeat (3) @(negedge mclk_in);
    drv = dq_oe_in;
    we_n = 1'b0;
    hdata = d;
    hdrive = 1'b1;
    repeat (2) @(negedge mclk_in);
    flt = !dq_oe_in;
    cs_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    // Address and data held past the strobe release
    @(negedge mclk_in);
    hdrive = 1'b0;
    last = d;
    @(negedge mclk_in);
  endtask

  task automatic rd(input logic [4:0] a, output rtcw_byte_t d, output logic drv);
    @(negedge mclk_in);
    addr = a;
    cs_n = 1'b0;
    oe_n = 1'b0;
    repeat (3) @(negedge mclk_in);
    d = dq_in;
    drv = dq_oe_in;
    cs_n = 1'b1;
    oe_n = 1'b1;
    last = d;
    @(negedge mclk_in);
  endtask
endmodule // rtcw_host
`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench of the real-time clock core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import rtcw_pkg::*;
;
  // Short counts keep the run small; the watchdog period and reset length checks derive from these
  localparam int RST = 20;
  localparam int TICK = 10;
  logic       mclk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       power_fail_in = 1'b0;
  rtcw_bus_s  bus;
  logic [7:0] dq;
  logic       dq_oe;
  logic       irq_oe;
  logic       pwr_oe;
  logic       rst_oe;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         n;
  int         t1;
  rtcw_byte_t v;
  logic       f;
  logic       g;

  initial forever #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc++;

  rtcw_core #(.RST_CYC(RST), .TICK_CYC(TICK)) DUT (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus), .power_fail_in(power_fail_in),
    .dq_out(dq), .dq_oe_out(dq_oe), .irq_oe_out(irq_oe), .power_on_oe_out(pwr_oe),
    .reset_oe_out(rst_oe));
  rtcw_host host (.mclk_in(mclk_in), .dq_in(dq), .dq_oe_in(dq_oe), .bus_out(bus));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic rchk(input logic [4:0] a, input rtcw_byte_t e);
    rtcw_byte_t r;
    logic       d;
    host.rd(a, r, d);
    `CHK(r, e)
  endtask

  task automatic wr(input logic [4:0] a, input rtcw_byte_t d);
    host.wr(a, d, 1'b0, f, g);
  endtask

  // Bounded wait on irq (0) or reset (1) pin enable; c counts cycles waited
  task automatic wait_lvl(input int s, input logic l, input int lim, output int c);
    c = 0;
    while (((s == 0) ? irq_oe : rst_oe) !== l && c < lim)
    begin
      @(negedge mclk_in);
      c++;
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    `CHK(rst_oe, 1'b0)
    rchk(5'h0F, 8'h80);
    rchk(5'h0C, 8'h00);
    rchk(5'h0D, 8'h00);
    rchk(5'h0E, 8'h00);
    rchk(5'h03, 8'h01);
  endtask

  task automatic t_access;
    wr(5'h08, 8'h12);
    rchk(5'h08, 8'h12);
    host.wr(5'h09, 8'h34, 1'b1, f, g);
    `CHK(f, 1'b1)
    `CHK(g, 1'b1)
    rchk(5'h09, 8'h34);
    wr(5'h13, 8'hAA);
    rchk(5'h13, 8'h00);
  endtask

  task automatic t_hold;
    wr(5'h0F, 8'h00);
    host.rd(5'h00, v, f);
    repeat (1200) @(negedge mclk_in);
    rchk(5'h00, v);
    wr(5'h00, 8'h45);
    wr(5'h0F, 8'hC0);
    rchk(5'h00, 8'h45);
    repeat (1200) @(negedge mclk_in);
    rchk(5'h00, 8'h45);
    wr(5'h0F, 8'h80);
    n = 0;
    do
    begin
      host.rd(5'h00, v, f);
      n++;
    end
    while (v === 8'h45 && n < 300);
    `CHK(v, 8'h46)
  endtask

  task automatic t_wdog;
    wr(5'h0C, 8'h10);
    wr(5'h0D, 8'h00);
    wr(5'h0F, 8'hA0);
    wait_lvl(0, 1'b1, 300, n);
    `CHK(irq_oe, 1'b1)
    t1 = cyc;
    rchk(5'h0E, 8'h06);
    wait_lvl(0, 1'b0, 8, n);
    `CHK(irq_oe, 1'b0)
    wait_lvl(0, 1'b1, 300, n);
    // BCD 10 means ten ticks, not sixteen
    `CHK((cyc - t1) >= 10 * TICK - 1 && (cyc - t1) <= 10 * TICK + 1, 1'b1)
    wr(5'h0C, 8'h10);
    host.rd(5'h0E, v, f);
    repeat (8)
    begin
      wr(5'h0C, 8'h10);
      repeat (15) @(negedge mclk_in);
    end
    rchk(5'h0E, 8'h00);
    wr(5'h0C, 8'h00);
    host.rd(5'h0E, v, f);
    repeat (300) @(negedge mclk_in);
    rchk(5'h0E, 8'h00);
  endtask

  task automatic t_wdrst;
    wr(5'h0F, 8'hB0);
    wr(5'h0C, 8'h02);
    wait_lvl(1, 1'b1, 100, n);
    wait_lvl(1, 1'b0, 1100, n);
    `CHK(n >= RST && n <= 5 * RST, 1'b1)
    rchk(5'h0F, 8'h90);
    rchk(5'h0E, 8'h02);
    wr(5'h0C, 8'h00);
    host.rd(5'h0E, v, f);
  endtask

  task automatic t_alarm;
    wr(5'h0F, 8'h8C);
    for (int i = 0; i < 2; i++)
    begin
      wr(5'h08, 8'h80);
      wr(5'h09, (i == 0) ? 8'h80 : 8'h00);
      wr(5'h0A, 8'h80);
      host.rd(5'h0E, v, f);
      wait_lvl(0, 1'b1, 1200, n);
      repeat (2) @(negedge mclk_in);
      `CHK(irq_oe, 1'b1)
      `CHK(pwr_oe, 1'b1)
      rchk(5'h0E, 8'h05);
      wait_lvl(0, 1'b0, 8, n);
      `CHK(irq_oe, 1'b0)
    end
    wr(5'h0F, 8'h80);
    host.rd(5'h0E, v, f);
    repeat (1100) @(negedge mclk_in);
    `CHK(irq_oe, 1'b0)
    `CHK(pwr_oe, 1'b0)
    rchk(5'h0E, 8'h01);
  endtask

  task automatic t_pfail;
    @(negedge mclk_in);
    power_fail_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    `CHK(rst_oe, 1'b1)
    wr(5'h08, 8'h55);
    host.rd(5'h08, v, f);
    `CHK(f, 1'b0)
    power_fail_in = 1'b0;
    wait_lvl(1, 1'b0, 1100, n);
    `CHK(n >= RST && n <= 5 * RST, 1'b1)
    rchk(5'h08, 8'h80);
  endtask

  // --------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // --------------------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    t_reset();
    t_access();
    t_hold();
    t_wdog();
    t_wdrst();
    t_alarm();
    t_pfail();
    print_verdict();
  end

  // Scenarios need about 6.4k cycles; generous margin before calling a hang
  initial
  begin
    repeat (40000) @(negedge mclk_in);
    miscompares++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
